// ### paging_defines.svh
`ifndef PAGING_DEFINES_SVH
`define PAGING_DEFINES_SVH

// Operation
// - Four-level top cache tag is address 47:39
// - Top entry keeps table address and flags
// - Top fill needs present, no reserved bits
// - Set accessed flag before top fill
// - Four-level third cache tag is 47:30
// - Third entry ANDs rights, ORs execute disable
// - Third fill needs present, small size, clean
// - Set both accessed flags before third fill
// - Directory tag width depends on mode
// - Directory entry combines rights over levels
// - Directory fill needs valid non-leaf levels
// - Set every accessed flag before directory fill
// - Stale entries may live until flushed
// - Only non-leaf data cached, global ignored
// - Entries tagged and matched by context
// - Speculative walks may fill the caches
// - TLB hit uses matching context or global
// - Directory hit resumes at leaf fetch
// - Third hit resumes at directory fetch
// - Top hit resumes at third fetch
// - Skip absent caches, else full walk
// - Entries may be dropped any time
// - Global TLB entry ignores context

`define LA_W 48
`define PA_W 52
`define FRAME_W 40
`define CTX_W 12
`define ENT_W 64
`define BIT_PRESENT 0
`define BIT_WRITE 1
`define BIT_USER 2
`define BIT_WTHRU 3
`define BIT_CDIS 4
`define BIT_ACCESSED 5
`define BIT_PSIZE 7
`define BIT_NOEXEC 63
`define RSVD_MASK 64'h7FF0_0000_0000_0000
`define ACC_MASK 64'h0000_0000_0000_0020
`define TOP_TAG_W 9
`define THIRD_TAG_W 18
`define DIR_TAG_W 29
`define TOP_ENTRIES 4
`define THIRD_ENTRIES 8
`define DIR_ENTRIES 16

`endif

// ### paging_pkg.sv
`include "paging_defines.svh"

package paging_pkg;

    typedef enum logic [1:0] {
        MODE_32 = 2'b00,
        MODE_EXT = 2'b01,
        MODE_4L = 2'b10
    } mode_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_LOOKUP = 3'b001,
        S_FETCH = 3'b010,
        S_CHECK = 3'b011,
        S_SETA = 3'b100
    } state_t;

    typedef struct packed {
        logic [`FRAME_W-1:0] addr;
        logic rw;
        logic us;
        logic execute_disable_flag;
        logic cache_disable_flag;
        logic write_through_flag;
    } pc_data_t;

    typedef struct packed {
        logic [`LA_W-1:0] la;
        logic [`CTX_W-1:0] ctx;
        mode_t mode;
        logic [`PA_W-1:0] root;
    } req_t;

    typedef struct packed {
        logic valid;
        logic [35:0] page;
        logic [`CTX_W-1:0] ctx;
        logic is_global;
        pc_data_t data;
    } tlb_t;

    typedef struct packed {
        logic fault;
        logic tlb_hit;
        pc_data_t data;
    } resp_t;

endpackage

// ### pscache.sv
`timescale 1ns/100ps
`include "paging_defines.svh"

module pscache import paging_pkg::*; #(
    parameter int ENTRIES = 4,
    parameter int TAG_W = 9
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Lookup
    input wire logic [TAG_W-1:0] lk_tag,
    input wire logic [`CTX_W-1:0] lk_ctx,
    output logic hit,
    output pc_data_t hit_data,
    // Fill
    input wire logic fill_en,
    input wire logic [TAG_W-1:0] fill_tag,
    input wire logic [`CTX_W-1:0] fill_ctx,
    input wire pc_data_t fill_data,
    // Flush
    input wire logic flush_all,
    input wire logic flush_ctx_en,
    input wire logic [`CTX_W-1:0] flush_ctx
);
    localparam int PTR_W = $clog2(ENTRIES);

    if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0) begin : g_chk
        $error("ENTRIES must be a power of two, at least 2");
    end

    logic [ENTRIES-1:0] vld_q;
    logic [ENTRIES-1:0] match;
    logic [ENTRIES-1:0] fmatch;
    logic [TAG_W-1:0] tag_q [ENTRIES];
    logic [`CTX_W-1:0] ctx_q [ENTRIES];
    pc_data_t dat_q [ENTRIES];
    logic [PTR_W-1:0] vict_q;
    logic fill_ok;

    // Flush beats a fill in the same cycle, so no stale entry slips in
    assign fill_ok = fill_en && !flush_all &&
        !(flush_ctx_en && fill_ctx == flush_ctx);

    for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
        logic kill;
        logic take;
        assign match[i] = vld_q[i] && tag_q[i] == lk_tag &&
            ctx_q[i] == lk_ctx;
        assign fmatch[i] = vld_q[i] && tag_q[i] == fill_tag &&
            ctx_q[i] == fill_ctx;
        assign kill = flush_all ||
            (flush_ctx_en && ctx_q[i] == flush_ctx);
        // Refill of a present tag overwrites it, so hits stay one-hot
        assign take = fill_ok && ((|fmatch) ? fmatch[i] :
            vict_q == PTR_W'(i));
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                vld_q[i] <= 1'b0;
            end else if (take) begin
                // A fill never carries a flushed context, so it may win
                vld_q[i] <= 1'b1;
            end else if (kill) begin
                vld_q[i] <= 1'b0;
            end
        end
        // Payload needs no reset; the valid bit guards it
        always_ff @(posedge clk) begin
            if (take) begin
                tag_q[i] <= fill_tag;
                ctx_q[i] <= fill_ctx;
                dat_q[i] <= fill_data;
            end
        end
    end

    // Round-robin victim; any entry may be dropped at any time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vict_q <= '0;
        end else if (fill_ok && !(|fmatch)) begin
            vict_q <= vict_q + PTR_W'(1);
        end
    end

    always_comb begin
        hit_data = '0;
        for (int k = 0; k < ENTRIES; k++) begin
            if (match[k]) begin
                hit_data = dat_q[k];
            end
        end
    end
    assign hit = |match;

    flush_clear_a: assert property (@(posedge clk) disable iff (rst)
        flush_all |=> vld_q == '0)
        else $error("flush left a valid entry");

    fill_visible_a: assert property (@(posedge clk) disable iff (rst)
        fill_ok ##1 (lk_tag == $past(fill_tag) &&
        lk_ctx == $past(fill_ctx) && !$past(flush_all)) |-> hit)
        else $error("filled entry not found on lookup");
endmodule

// ### paging_structure_cache.sv
`timescale 1ns/100ps
`include "paging_defines.svh"

module paging_structure_cache import paging_pkg::*; #(
    parameter int TOP_ENTRIES = `TOP_ENTRIES,
    parameter int THIRD_ENTRIES = `THIRD_ENTRIES,
    parameter int DIR_ENTRIES = `DIR_ENTRIES,
    parameter bit IMPL_TOP = 1'b1,
    parameter bit IMPL_THIRD = 1'b1,
    parameter bit IMPL_DIR = 1'b1
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Translation request
    input wire logic REQ_VALID,
    input wire req_t REQ,
    output logic REQ_READY,
    // TLB probe result for the request
    input wire tlb_t TLB,
    // Translation answer
    output logic RESP_VALID,
    output resp_t RESP,
    // Table memory
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [`PA_W-1:0] MEM_ADDR,
    output logic [`ENT_W-1:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic [`ENT_W-1:0] MEM_RDATA,
    // Flush
    input wire logic FLUSH_ALL,
    input wire logic FLUSH_CTX_EN,
    input wire logic [`CTX_W-1:0] FLUSH_CTX
);
    state_t st_q, st_d;
    req_t req_q;
    logic [`PA_W-1:0] base_q;
    logic [1:0] lvl_q;
    logic rw_q, us_q, noexec_q;
    logic [`ENT_W-1:0] ent_q;
    logic ready_q, resp_valid_q;
    resp_t resp_q;
    logic mem_req_q, mem_we_q;
    logic [`PA_W-1:0] mem_addr_q;
    logic [`ENT_W-1:0] mem_wdata_q;

    assign REQ_READY = ready_q;
    assign RESP_VALID = resp_valid_q;
    assign RESP = resp_q;
    assign MEM_REQ = mem_req_q;
    assign MEM_WE = mem_we_q;
    assign MEM_ADDR = mem_addr_q;
    assign MEM_WDATA = mem_wdata_q;

    // Byte offset of the entry within its table
    function automatic logic [11:0] ent_off(mode_t m, logic [1:0] l,
                                            logic [`LA_W-1:0] la);
        logic [11:0] o;
        o = 12'h000;
        if (m == MODE_32) begin
            o = (l == 2'h1) ? {la[31:22], 2'b00} : {la[21:12], 2'b00};
        end else begin
            case (l)
                2'h3: o = {la[47:39], 3'b000};
                2'h2: o = (m == MODE_EXT) ? {7'h00, la[31:30], 3'b000} :
                    {la[38:30], 3'b000};
                2'h1: o = {la[29:21], 3'b000};
                default: o = {la[20:12], 3'b000};
            endcase
        end
        return o;
    endfunction

    // Mode kept in the tag so entries of other modes never alias
    function automatic logic [`DIR_TAG_W-1:0] dir_tag(mode_t m,
                                                     logic [`LA_W-1:0] la);
        logic [`DIR_TAG_W-1:0] t;
        t = '0;
        case (m)
            MODE_32: t = {m, 17'h0_0000, la[31:22]};
            MODE_EXT: t = {m, 16'h0000, la[31:21]};
            default: t = {m, la[47:21]};
        endcase
        return t;
    endfunction

    // Entry decode
    logic is32, is4l;
    logic e_p, e_rw, e_us, e_wthru, e_nocache, e_a, e_sz, e_noexec, e_rsvd;
    logic [`FRAME_W-1:0] e_addr, leaf_frame;
    logic e_bad, e_leaf, rw_n, us_n, noexec_n;
    logic descend, finish, need_a, fault;
    assign is32 = req_q.mode == MODE_32;
    assign is4l = req_q.mode == MODE_4L;
    assign e_p = ent_q[`BIT_PRESENT];
    assign e_rw = ent_q[`BIT_WRITE];
    assign e_us = ent_q[`BIT_USER];
    assign e_wthru = ent_q[`BIT_WTHRU];
    assign e_nocache = ent_q[`BIT_CDIS];
    assign e_a = ent_q[`BIT_ACCESSED];
    assign e_sz = ent_q[`BIT_PSIZE];
    assign e_noexec = !is32 && ent_q[`BIT_NOEXEC];
    assign e_rsvd = !is32 && (|(ent_q & `RSVD_MASK));
    assign e_addr = is32 ? {20'h0_0000, ent_q[31:12]} : ent_q[51:12];
    // Size flag is illegal at the top, and above directory outside 4L
    assign e_bad = !e_p || e_rsvd || (e_sz && lvl_q == 2'h3) ||
        (e_sz && lvl_q == 2'h2 && !is4l);
    assign e_leaf = lvl_q == 2'h0 || e_sz;
    assign rw_n = rw_q & e_rw;
    assign us_n = us_q & e_us;
    assign noexec_n = noexec_q | e_noexec;
    assign descend = st_q == S_CHECK && !e_bad && e_a && !e_leaf;
    assign finish = st_q == S_CHECK && !e_bad && e_a && e_leaf;
    assign need_a = st_q == S_CHECK && !e_bad && !e_a;
    assign fault = st_q == S_CHECK && e_bad;
    assign leaf_frame = (lvl_q == 2'h0) ? e_addr :
        (lvl_q == 2'h2) ? {e_addr[39:18], req_q.la[29:12]} :
        is32 ? {e_addr[39:10], req_q.la[21:12]} :
        {e_addr[39:9], req_q.la[20:12]};

    // Fills happen only once the entry passed checks with accessed set
    logic fill_top, fill_third, fill_dir;
    pc_data_t fill_data;
    assign fill_top = IMPL_TOP && descend && lvl_q == 2'h3;
    assign fill_third = IMPL_THIRD && descend && lvl_q == 2'h2 &&
        is4l;
    assign fill_dir = IMPL_DIR && descend && lvl_q == 2'h1;
    assign fill_data = '{e_addr, rw_n, us_n, noexec_n, e_nocache,
        e_wthru};

    // Lookup side
    logic top_hit, third_hit, dir_hit;
    logic top_use, third_use, dir_use, tlb_use;
    pc_data_t top_data, third_data, dir_data, hd;
    assign top_use = IMPL_TOP && top_hit && is4l;
    assign third_use = IMPL_THIRD && third_hit && is4l;
    assign dir_use = IMPL_DIR && dir_hit;
    assign hd = dir_use ? dir_data : third_use ? third_data : top_data;
    assign tlb_use = TLB.valid && TLB.page == REQ.la[47:12] &&
        (TLB.ctx == REQ.ctx || TLB.is_global);

    pscache #(.ENTRIES(TOP_ENTRIES), .TAG_W(`TOP_TAG_W)) u_top (
        .clk(CLK_SYS), .rst(RST),
        .lk_tag(req_q.la[47:39]), .lk_ctx(req_q.ctx),
        .hit(top_hit), .hit_data(top_data),
        .fill_en(fill_top), .fill_tag(req_q.la[47:39]),
        .fill_ctx(req_q.ctx), .fill_data(fill_data),
        .flush_all(FLUSH_ALL), .flush_ctx_en(FLUSH_CTX_EN),
        .flush_ctx(FLUSH_CTX)
    );

    pscache #(.ENTRIES(THIRD_ENTRIES), .TAG_W(`THIRD_TAG_W)) u_third (
        .clk(CLK_SYS), .rst(RST),
        .lk_tag(req_q.la[47:30]), .lk_ctx(req_q.ctx),
        .hit(third_hit), .hit_data(third_data),
        .fill_en(fill_third), .fill_tag(req_q.la[47:30]),
        .fill_ctx(req_q.ctx), .fill_data(fill_data),
        .flush_all(FLUSH_ALL), .flush_ctx_en(FLUSH_CTX_EN),
        .flush_ctx(FLUSH_CTX)
    );

    pscache #(.ENTRIES(DIR_ENTRIES), .TAG_W(`DIR_TAG_W)) u_dir (
        .clk(CLK_SYS), .rst(RST),
        .lk_tag(dir_tag(req_q.mode, req_q.la)), .lk_ctx(req_q.ctx),
        .hit(dir_hit), .hit_data(dir_data),
        .fill_en(fill_dir), .fill_tag(dir_tag(req_q.mode, req_q.la)),
        .fill_ctx(req_q.ctx), .fill_data(fill_data),
        .flush_all(FLUSH_ALL), .flush_ctx_en(FLUSH_CTX_EN),
        .flush_ctx(FLUSH_CTX)
    );

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            S_IDLE: if (REQ_VALID && !tlb_use) st_d = S_LOOKUP;
            S_LOOKUP: st_d = S_FETCH;
            S_FETCH: if (mem_req_q && MEM_ACK) st_d = S_CHECK;
            S_CHECK: begin
                if (fault || finish) begin
                    st_d = S_IDLE;
                end else if (need_a) begin
                    st_d = S_SETA;
                end else begin
                    st_d = S_FETCH;
                end
            end
            S_SETA: if (mem_req_q && MEM_ACK) st_d = S_CHECK;
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_q <= S_IDLE;
            ready_q <= 1'b1;
        end else begin
            st_q <= st_d;
            ready_q <= st_d == S_IDLE;
        end
    end

    // Walk position; caches are never snooped, stale data stays
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            req_q <= '0;
            base_q <= '0;
            lvl_q <= 2'h0;
            rw_q <= 1'b1;
            us_q <= 1'b1;
            noexec_q <= 1'b0;
        end else if (st_q == S_IDLE && REQ_VALID) begin
            req_q <= REQ;
        end else if (st_q == S_LOOKUP) begin
            if (dir_use || third_use || top_use) begin
                base_q <= {hd.addr, 12'h000};
                rw_q <= hd.rw;
                us_q <= hd.us;
                noexec_q <= hd.execute_disable_flag;
                lvl_q <= dir_use ? 2'h0 :
                    third_use ? 2'h1 : 2'h2;
            end else begin
                base_q <= req_q.root;
                rw_q <= 1'b1;
                us_q <= 1'b1;
                noexec_q <= 1'b0;
                lvl_q <= is4l ? 2'h3 : is32 ? 2'h1 : 2'h2;
            end
        end else if (descend) begin
            base_q <= {e_addr, 12'h000};
            lvl_q <= lvl_q - 2'h1;
            // Extended mode takes no rights from its third-level entry, only from directory and leaf
            if (is4l || lvl_q != 2'h2) begin
                rw_q <= rw_n;
                us_q <= us_n;
                noexec_q <= noexec_n;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ent_q <= '0;
        end else if (mem_req_q && MEM_ACK) begin
            ent_q <= (st_q == S_SETA) ? (ent_q | `ACC_MASK) : MEM_RDATA;
        end
    end

    // Request held until acknowledged
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= '0;
            mem_wdata_q <= '0;
        end else if (mem_req_q && MEM_ACK) begin
            mem_req_q <= 1'b0;
        end else if (!mem_req_q && st_q == S_FETCH) begin
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            mem_addr_q <= base_q +
                {40'h00_0000_0000, ent_off(req_q.mode, lvl_q, req_q.la)};
        end else if (!mem_req_q && st_q == S_SETA) begin
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b1;
            mem_wdata_q <= ent_q | `ACC_MASK;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            resp_valid_q <= 1'b0;
            resp_q <= '0;
        end else begin
            resp_valid_q <= 1'b0;
            if (st_q == S_IDLE && REQ_VALID && tlb_use) begin
                resp_valid_q <= 1'b1;
                resp_q <= '{1'b0, 1'b1, TLB.data};
            end else if (finish) begin
                resp_valid_q <= 1'b1;
                resp_q <= '{1'b0, 1'b0,
                    '{leaf_frame, rw_n, us_n, noexec_n, e_nocache, e_wthru}};
            end else if (fault) begin
                resp_valid_q <= 1'b1;
                resp_q <= '{1'b1, 1'b0, '0};
            end
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence s_miss;
        st_q == S_LOOKUP && !dir_use && !third_use && !top_use;
    endsequence
    sequence s_seta;
        need_a ##1 st_q == S_SETA;
    endsequence

    top_fill_a: assert property (fill_top |-> is4l && e_p && !e_rsvd)
        else $error("top-level fill of invalid entry");
    fill_accessed_a: assert property ((fill_top || fill_third || fill_dir)
        |-> e_a && $past(st_q) != S_IDLE)
        else $error("fill without accessed flag");
    third_size_a: assert property (fill_third |-> !e_sz && lvl_q == 2'h2)
        else $error("third-level fill of large page");
    tlb_fast_a: assert property (st_q == S_IDLE && REQ_VALID && tlb_use
        |=> RESP_VALID && RESP.tlb_hit && !RESP.fault)
        else $error("TLB hit not answered next cycle");
    root_walk_a: assert property (s_miss |=> base_q == $past(req_q.root)
        ##1 MEM_REQ && !MEM_WE)
        else $error("miss did not start walk at root");
    accessed_write_a: assert property (s_seta |=> MEM_REQ && MEM_WE &&
        MEM_WDATA[`BIT_ACCESSED] && MEM_ADDR == $past(MEM_ADDR, 2))
        else $error("accessed flag write missing");
    dir_resume_a: assert property (st_q == S_LOOKUP && dir_use
        |=> lvl_q == 2'h0 && st_q == S_FETCH)
        else $error("directory hit did not resume at leaf");
    third_resume_a: assert property (st_q == S_LOOKUP && !dir_use &&
        third_use |=> lvl_q == 2'h1)
        else $error("third-level hit did not resume at directory");
    top_resume_a: assert property (st_q == S_LOOKUP && !dir_use &&
        !third_use && top_use |=> lvl_q == 2'h2)
        else $error("top-level hit did not resume at third level");
    fault_resp_a: assert property (fault |=>
        RESP_VALID && RESP.fault && REQ_READY)
        else $error("bad entry not reported as fault");
endmodule

// ### table_mem.sv
`timescale 1ns/100ps
`include "paging_defines.svh"

module table_mem (
    // Clock
    input wire logic clk,
    // Table memory port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [`PA_W-1:0] mem_addr,
    input wire logic [`ENT_W-1:0] mem_wdata,
    output logic mem_ack,
    output logic [`ENT_W-1:0] mem_rdata
);
    logic [`ENT_W-1:0] mem [logic [`PA_W-1:0]];
    int lat = 1;
    int waited = 0;

    // Untouched entries chain to the next page, present and accessed
    function automatic logic [`ENT_W-1:0] peek(logic [`PA_W-1:0] a);
        if (mem.exists(a)) begin
            return mem[a];
        end
        return {12'h000, a[51:12] + 40'h1, 12'h027};
    endfunction

    task automatic put(logic [`PA_W-1:0] a, logic [`ENT_W-1:0] d);
        mem[a] = d;
    endtask

    initial begin
        mem_ack = 1'b0;
        mem_rdata = '0;
    end

    // Data toggles outside an answer so a late sample never looks valid
    always @(posedge clk) begin
        mem_rdata <= ~mem_rdata;
        if (mem_ack) begin
            mem_ack <= 1'b0;
            waited <= 0;
        end else if (mem_req && waited + 1 >= lat) begin
            mem_ack <= 1'b1;
            if (mem_we) begin
                mem[mem_addr] = mem_wdata;
            end else begin
                mem_rdata <= peek(mem_addr);
            end
        end else if (mem_req) begin
            waited <= waited + 1;
        end
    end
endmodule

// ### paging_structure_cache_test.sv
`timescale 1ns/100ps
`include "paging_defines.svh"

module paging_structure_cache_test import paging_pkg::*; ;
    localparam logic [`PA_W-1:0] ROOT = 52'h0_0000_0001_0000;
    localparam logic [`LA_W-1:0] LA_A = 48'h0000_4020_3000;
    localparam logic [`LA_W-1:0] LA_B = 48'h0080_0000_0000;
    localparam logic [`LA_W-1:0] LA_C = 48'h0100_0000_0000;
    localparam logic [`LA_W-1:0] LA_D = 48'h0181_4000_0000;
    localparam logic [`LA_W-1:0] LA_E = 48'h0200_0000_0000;

    typedef struct {
        logic [`LA_W-1:0] la;
        logic [`CTX_W-1:0] ctx;
        mode_t mode;
        logic tv;
        logic tg;
        logic [`CTX_W-1:0] tctx;
        resp_t exp;
        int reads;
    } row_t;

    logic CLK_SYS, RST, REQ_VALID, REQ_READY, RESP_VALID;
    logic MEM_REQ, MEM_WE, MEM_ACK, FLUSH_ALL, FLUSH_CTX_EN;
    logic [`PA_W-1:0] MEM_ADDR;
    logic [`ENT_W-1:0] MEM_WDATA, MEM_RDATA;
    logic [`CTX_W-1:0] FLUSH_CTX;
    req_t REQ;
    tlb_t TLB;
    resp_t RESP, got, w4, w32, wex, wxd, wgb, wflt, wtlb;
    pc_data_t tlb_d;
    int n_fail = 0;
    int n_tests = 0;
    int n_rd = 0;
    int n_wr = 0;
    int cyc = 0;
    row_t rows[12];

    paging_structure_cache u_paging_structure_cache (
        .CLK_SYS(CLK_SYS), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
        .REQ_READY(REQ_READY), .TLB(TLB), .RESP_VALID(RESP_VALID),
        .RESP(RESP), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
        .MEM_RDATA(MEM_RDATA), .FLUSH_ALL(FLUSH_ALL),
        .FLUSH_CTX_EN(FLUSH_CTX_EN), .FLUSH_CTX(FLUSH_CTX));

    table_mem u_table_mem (
        .clk(CLK_SYS), .mem_req(MEM_REQ), .mem_we(MEM_WE),
        .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA), .mem_ack(MEM_ACK),
        .mem_rdata(MEM_RDATA));

    initial begin
        CLK_SYS = 1'b0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end

    // Table traffic is counted per request to see which levels were cached
    always @(posedge CLK_SYS) begin
        cyc++;
        if (MEM_REQ === 1'b1 && MEM_ACK === 1'b1) begin
            if (MEM_WE) begin
                n_wr++;
            end else begin
                n_rd++;
            end
        end
        if (cyc == 8000) begin
            n_fail++;
            close_out();
        end
    end

    function automatic resp_t mk(logic f, logic h, logic [39:0] fr,
                                 logic [2:0] rux);
        return '{f, h, '{fr, rux[2], rux[1], rux[0], 1'b0, 1'b0}};
    endfunction

    task automatic chk_resp(string what, resp_t exp, resp_t seen);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_val(string what, logic [63:0] exp, logic [63:0] seen);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic run(row_t r);
        int k;
        logic tlb_ok;
        tlb_ok = r.tv && (r.tg || r.tctx == r.ctx);
        @(posedge CLK_SYS);
        REQ_VALID <= 1'b1;
        REQ <= '{r.la, r.ctx, r.mode, ROOT};
        TLB <= '{r.tv, r.la[47:12], r.tctx, r.tg, tlb_d};
        @(negedge CLK_SYS);
        n_rd = 0;
        n_wr = 0;
        @(posedge CLK_SYS);
        REQ_VALID <= 1'b0;
        k = 0;
        do begin
            @(negedge CLK_SYS);
            k++;
            if (k == 1) begin
                chk_val("ready at take", 64'(tlb_ok), 64'(REQ_READY));
            end
        end while (RESP_VALID !== 1'b1 && k < 300);
        chk_val("answer strobe", 64'(1), 64'(RESP_VALID));
        chk_val("ready at answer", 64'(1), 64'(REQ_READY));
        got = RESP;
    endtask

    task automatic go(logic [`LA_W-1:0] la, logic [`CTX_W-1:0] ctx,
                      resp_t exp, int reads);
        run('{la, ctx, MODE_4L, 1'b0, 1'b0, 12'h000, exp, reads});
        chk_resp("walk answer", exp, got);
        chk_val("table reads", 64'(reads), 64'(n_rd));
    endtask

    task automatic do_reset(int n);
        @(posedge CLK_SYS);
        RST <= 1'b1;
        repeat (n) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk_val("ready in reset", 64'(1), 64'(REQ_READY));
        chk_val("strobe in reset", 64'(0), 64'({RESP_VALID, MEM_REQ}));
        chk_resp("answer in reset", '0, RESP);
        @(posedge CLK_SYS);
        RST <= 1'b0;
    endtask

    task automatic flush(logic all, logic [`CTX_W-1:0] ctx);
        @(posedge CLK_SYS);
        FLUSH_ALL <= all;
        FLUSH_CTX_EN <= ~all;
        FLUSH_CTX <= ctx;
        @(posedge CLK_SYS);
        FLUSH_ALL <= 1'b0;
        FLUSH_CTX_EN <= 1'b0;
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        RST = 1'b1;
        REQ_VALID = 1'b0;
        REQ = '0;
        TLB = '0;
        FLUSH_ALL = 1'b0;
        FLUSH_CTX_EN = 1'b0;
        FLUSH_CTX = '0;
        tlb_d = '{40'hABC, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        w4 = mk(1'b0, 1'b0, 40'h14, 3'b110);
        w32 = mk(1'b0, 1'b0, 40'h12, 3'b110);
        wex = mk(1'b0, 1'b0, 40'h13, 3'b110);
        wxd = mk(1'b0, 1'b0, 40'h14, 3'b011);
        wgb = mk(1'b0, 1'b0, 40'h40000, 3'b110);
        wflt = mk(1'b1, 1'b0, 40'h0, 3'b000);
        wtlb = mk(1'b0, 1'b1, 40'hABC, 3'b101);
        rows[0] = '{LA_A, 12'h1, MODE_4L, 1'b0, 1'b0, 12'h0, w4, 4};
        rows[1] = '{48'h4020_4000, 12'h1, MODE_4L, 1'b0, 1'b0, 12'h0, w4, 1};
        rows[2] = '{48'h4040_3000, 12'h1, MODE_4L, 1'b0, 1'b0, 12'h0, w4, 2};
        rows[3] = '{48'h8020_3000, 12'h1, MODE_4L, 1'b0, 1'b0, 12'h0, w4, 3};
        rows[4] = '{LA_A, 12'h2, MODE_4L, 1'b0, 1'b0, 12'h0, w4, 4};
        rows[5] = '{LA_A, 12'h1, MODE_4L, 1'b1, 1'b0, 12'h1, wtlb, 0};
        rows[6] = '{LA_A, 12'h1, MODE_4L, 1'b1, 1'b1, 12'h7, wtlb, 0};
        rows[7] = '{LA_A, 12'h1, MODE_4L, 1'b1, 1'b0, 12'h7, w4, 1};
        rows[8] = '{48'h40_5000, 12'h1, MODE_32, 1'b0, 1'b0, 12'h0, w32, 2};
        rows[9] = '{48'h40_6000, 12'h1, MODE_32, 1'b0, 1'b0, 12'h0, w32, 1};
        rows[10] = '{LA_A, 12'h1, MODE_EXT, 1'b0, 1'b0, 12'h0, wex, 3};
        rows[11] = '{48'h4020_4000, 12'h1, MODE_EXT, 1'b0, 1'b0, 12'h0, wex, 1};
        do_reset(20);
        for (int i = 0; i < 12; i++) begin
            run(rows[i]);
            chk_resp("row answer", rows[i].exp, got);
            chk_val("row reads", 64'(rows[i].reads), 64'(n_rd));
        end
        // A stale directory entry keeps serving until flushed
        u_table_mem.put(52'h12008, 64'h99027);
        go(LA_A, 12'h001, w4, 1);
        u_table_mem.put(52'h12008, 64'h13027);
        flush(1'b0, 12'h001);
        go(LA_A, 12'h001, w4, 4);
        go(LA_A, 12'h002, w4, 1);
        flush(1'b1, 12'h000);
        go(LA_A, 12'h002, w4, 4);
        // Accessed flags clear at top and third level
        u_table_mem.put(52'h10008, 64'h11007);
        u_table_mem.put(52'h11000, 64'h12007);
        go(LA_B, 12'h001, w4, 4);
        chk_val("flag writes", 64'(2), 64'(n_wr));
        chk_val("top flag", 64'h11027, u_table_mem.peek(52'h10008));
        chk_val("third flag", 64'h12027, u_table_mem.peek(52'h11000));
        go(LA_B + 48'h20_0000, 12'h001, w4, 2);
        go(LA_B + 48'h4000_0000, 12'h001, w4, 3);
        // Directory entry is kept although its leaf is not present
        u_table_mem.put(52'h13038, 64'h0);
        go(LA_B + 48'h60_7000, 12'h001, wflt, 2);
        go(LA_B + 48'h60_0000, 12'h001, w4, 1);
        // Rights combine down through the cached levels
        u_table_mem.put(52'h10010, 64'h8000_0000_0001_1025);
        go(LA_C, 12'h001, wxd, 4);
        go(LA_C + 48'h4000_0000, 12'h001, wxd, 3);
        go(LA_C + 48'h20_0000, 12'h001, wxd, 2);
        go(LA_C + 48'h1000, 12'h001, wxd, 1);
        // Slow memory until the last reset
        u_table_mem.lat = 3;
        u_table_mem.put(52'h11028, 64'h4000_00A7);
        go(LA_D, 12'h001, wgb, 2);
        go(LA_D, 12'h001, wgb, 1);
        u_table_mem.put(52'h10020, 64'h11026);
        go(LA_E, 12'h001, wflt, 1);
        chk_val("flag writes", 64'(0), 64'(n_wr));
        go(LA_E, 12'h001, wflt, 1);
        u_table_mem.lat = 1;
        do_reset(3);
        go(LA_A, 12'h002, w4, 4);
        close_out();
    end
endmodule
